// [fsgd_array_model.sv]
// flash array stand-in: ends each forwarded rewrite after a set delay
// assumes one rewrite at a time; go pulses come from the guard on clk
`timescale 1ns/1ps
`default_nettype none
module fsgd_array_model (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       rw_go,
  input  wire logic [7:0] delay,
  output var  logic       rw_done
);
  logic [7:0] cnt_r;

  // done pulses delay cycles after go; delay of zero is never used
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r   <= 8'h00;
      rw_done <= 1'b0;
    end else begin
      rw_done <= (cnt_r == 8'h01);
      if (rw_go) begin
        cnt_r <= delay;
      end else if (cnt_r != 8'h00) begin
        cnt_r <= cnt_r - 8'h01;
      end
    end
  end
endmodule : fsgd_array_model
`default_nettype wire

// [fsgd_defines.svh]
// constants for the flash rewrite guard and data store gate
// assumes a single 125 MHz clock; include by bare name
//
// How it works
// - self-programming code rewrites confined to shield window
// - window start/end set from either source
// - boot cluster 0 lock beats window
// - window never restricts data store
// - erase lock refuses serial code erase
// - write lock refuses serial code write
// - boot cluster 0 lock refuses code rewrites of blocks 0 to 3
// - locks default off, set freely, combinable
// - erase and boot locks never clear; nrst here still resets all locks to zero
// - write lock release only when blank
// - release applies at next device reset
// - data store: 1K block erase, byte writes
// - no instruction fetch from data store
// - code fetch served during data rewrite
// - data access blocked during self-programming code rewrite
// - busy data rewrite: control frozen, no stop
// - control resets zero, bit0 enables store
// - enable setup time blocks data access
// - first read after cpu_clock_source_sel falls, if read while high, undefined
`ifndef FSGD_DEFINES_SVH
`define FSGD_DEFINES_SVH

`define FSGD_CLK_MHZ        125
`define FSGD_CTL_RESET      8'h00
`define FSGD_CTL_EN_BIT     0
`define FSGD_BC0_LAST_BLK   8'h03

`define FSGD_T_SETUP_HS_NS  5000
`define FSGD_T_SETUP_LS_NS  720
`define FSGD_T_SETUP_LV_NS  10000
`define FSGD_T_CLKSW_HS_NS  5000
`define FSGD_T_CLKSW_LS_NS  1000
`define FSGD_T_CLKSW_LV_NS  10000

`define FSGD_CY_SETUP_HS ((`FSGD_T_SETUP_HS_NS * `FSGD_CLK_MHZ + 999) / 1000)
`define FSGD_CY_SETUP_LS ((`FSGD_T_SETUP_LS_NS * `FSGD_CLK_MHZ + 999) / 1000)
`define FSGD_CY_SETUP_LV ((`FSGD_T_SETUP_LV_NS * `FSGD_CLK_MHZ + 999) / 1000)
`define FSGD_CY_CLKSW_HS ((`FSGD_T_CLKSW_HS_NS * `FSGD_CLK_MHZ + 999) / 1000)
`define FSGD_CY_CLKSW_LS ((`FSGD_T_CLKSW_LS_NS * `FSGD_CLK_MHZ + 999) / 1000)
`define FSGD_CY_CLKSW_LV ((`FSGD_T_CLKSW_LV_NS * `FSGD_CLK_MHZ + 999) / 1000)

`endif

// [fsgd_guard.sv]
// flash rewrite guard: shield window, sticky locks, data store gate
// assumes all inputs come from logic on clk; warm_rst_evt marks a
// device reset that does not clear the nonvolatile lock state
`timescale 1ns/1ps
`include "fsgd_defines.svh"
`default_nettype none
module fsgd_guard (
  input  wire logic                  clk,
  input  wire logic                  nrst,
  input  wire logic                  warm_rst_evt,
  input  wire fsgd_pkg::fsgd_mode_t  flash_mode,
  input  wire logic                  rw_req_valid,
  input  wire fsgd_pkg::fsgd_rw_req_t rw_req,
  input  wire logic                  rw_done,
  input  wire logic                  win_set_valid,
  input  wire logic [7:0]            win_start,
  input  wire logic [7:0]            win_end,
  input  wire logic                  sec_set_valid,
  input  wire fsgd_pkg::fsgd_sec_t   sec_set_bits,
  input  wire logic                  rel_valid,
  input  wire fsgd_pkg::fsgd_src_t   rel_src,
  input  wire logic                  code_blank,
  input  wire logic                  data_blank,
  input  wire logic                  ctl_wr,
  input  wire logic                  ctl_bit_wr,
  input  wire logic [2:0]            ctl_bit_sel,
  input  wire logic [7:0]            ctl_wdata,
  input  wire logic                  ds_rd_req,
  input  wire logic                  ds_rd_fetch,
  input  wire logic                  cf_req,
  input  wire logic                  stop_req,
  input  wire logic                  cpu_clock_source_sel,
  output var  logic                  rw_go_r,
  output var  fsgd_pkg::fsgd_rw_req_t rw_out_r,
  output var  logic                  rw_fail_r,
  output var  logic                  rel_fail_r,
  output var  fsgd_pkg::fsgd_sec_t   sec_r,
  output var  logic                  code_busy_r,
  output var  logic                  data_busy_r,
  output var  logic [7:0]            data_store_control_r,
  output var  logic                  ds_rd_grant_r,
  output var  logic                  ds_rd_deny_r,
  output var  logic                  ds_rd_undef_r,
  output var  logic                  cf_grant_r,
  output var  logic                  stop_ok_r,
  output var  logic                  stop_deny_r
);

  ////////////////////////////////////////////////////////////////////
  // timers: enable setup and clock-switch settle

  logic        setup_busy_r;
  logic        clksw_busy_r;
  logic        setup_load;
  logic        setup_clear;
  logic        clksw_load;
  logic [10:0] setup_count;
  logic [10:0] clksw_count;

  always_comb begin
    unique case (flash_mode)
      fsgd_pkg::FSGD_HIGH_SPEED_MAIN: begin
        setup_count = 11'(`FSGD_CY_SETUP_HS);
        clksw_count = 11'(`FSGD_CY_CLKSW_HS);
      end
      fsgd_pkg::FSGD_LOW_SPEED_MAIN: begin
        setup_count = 11'(`FSGD_CY_SETUP_LS);
        clksw_count = 11'(`FSGD_CY_CLKSW_LS);
      end
      default: begin
        setup_count = 11'(`FSGD_CY_SETUP_LV);
        clksw_count = 11'(`FSGD_CY_CLKSW_LV);
      end
    endcase
  end

  fsgd_timer u_setup (
    .clk    (clk),
    .nrst   (nrst),
    .load   (setup_load),
    .count  (setup_count),
    .clear  (setup_clear),
    .busy_r (setup_busy_r)
  );

  fsgd_timer u_clksw (
    .clk    (clk),
    .nrst   (nrst),
    .load   (clksw_load),
    .count  (clksw_count),
    .clear  (1'b0),
    .busy_r (clksw_busy_r)
  );

  ////////////////////////////////////////////////////////////////////
  // rewrite decision and lock state

  logic [7:0]            win_start_r;
  logic [7:0]            win_end_r;
  logic [7:0]            win_start_nxt;
  logic [7:0]            win_end_nxt;
  logic                  rel_pend_r;
  logic                  rel_pend_nxt;
  fsgd_pkg::fsgd_sec_t   sec_nxt;
  logic                  rw_go_nxt;
  logic                  rw_fail_nxt;
  logic                  rel_fail_nxt;
  fsgd_pkg::fsgd_rw_req_t rw_out_nxt;
  logic                  code_busy_nxt;
  logic                  data_busy_nxt;
  logic                  is_code;
  logic                  is_self;
  logic                  in_bc0;
  logic                  out_win;
  logic                  rw_refuse;
  logic                  rel_ok;

  always_comb begin
    is_code = (rw_req.store == fsgd_pkg::FSGD_STORE_CODE);
    is_self = (rw_req.src == fsgd_pkg::FSGD_SRC_SELF);
    in_bc0  = is_code && (rw_req.block <= `FSGD_BC0_LAST_BLK);
    out_win = (rw_req.block < win_start_r) || (rw_req.block > win_end_r);
    rw_refuse = code_busy_r || data_busy_r
              || (in_bc0 && sec_r.bc0_lock)
              || (is_code && is_self && out_win)
              || (is_code && !is_self && sec_r.erase_lock
                  && rw_req.op == fsgd_pkg::FSGD_OP_ERASE)
              || (is_code && !is_self && sec_r.write_lock
                  && rw_req.op == fsgd_pkg::FSGD_OP_WRITE)
              || (!is_code && rw_req.op == fsgd_pkg::FSGD_OP_WRITE
                  && rw_req.wide);
    rel_ok = (rel_src == fsgd_pkg::FSGD_SRC_SERIAL) && !sec_r.erase_lock
             && !sec_r.bc0_lock && code_blank && data_blank;

    rw_go_nxt     = rw_req_valid && !rw_refuse;
    rw_fail_nxt   = rw_req_valid && rw_refuse;
    rw_out_nxt    = rw_req_valid ? rw_req : rw_out_r;
    code_busy_nxt = code_busy_r;
    data_busy_nxt = data_busy_r;
    if (rw_done) begin
      code_busy_nxt = 1'b0;
      data_busy_nxt = 1'b0;
    end
    if (rw_go_nxt) begin
      code_busy_nxt = is_code && is_self;
      data_busy_nxt = !is_code;
    end

    win_start_nxt = win_start_r;
    win_end_nxt   = win_end_r;
    if (win_set_valid) begin
      win_start_nxt = win_start;
      win_end_nxt   = win_end;
    end

    sec_nxt      = sec_r;
    rel_pend_nxt = rel_pend_r;
    rel_fail_nxt = rel_valid && !rel_ok;
    if (warm_rst_evt && rel_pend_r) begin
      sec_nxt.write_lock = 1'b0;
      rel_pend_nxt       = 1'b0;
    end
    if (rel_valid && rel_ok) begin
      rel_pend_nxt = 1'b1;
    end
    if (sec_set_valid) begin
      sec_nxt = sec_nxt | sec_set_bits;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sec_r       <= '0;
      rel_pend_r  <= 1'b0;
      win_start_r <= 8'h00;
      win_end_r   <= 8'hff;
      rw_go_r     <= 1'b0;
      rw_fail_r   <= 1'b0;
      rel_fail_r  <= 1'b0;
      rw_out_r    <= '0;
      code_busy_r <= 1'b0;
      data_busy_r <= 1'b0;
    end else begin
      sec_r       <= sec_nxt;
      rel_pend_r  <= rel_pend_nxt;
      win_start_r <= win_start_nxt;
      win_end_r   <= win_end_nxt;
      rw_go_r     <= rw_go_nxt;
      rw_fail_r   <= rw_fail_nxt;
      rel_fail_r  <= rel_fail_nxt;
      rw_out_r    <= rw_out_nxt;
      code_busy_r <= code_busy_nxt;
      data_busy_r <= data_busy_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // data store control, read gate, stop, clock switch

  logic [7:0] ctl_nxt;
  logic       cls_q_r;
  logic       sub_read_r;
  logic       dummy_pend_r;
  logic       sub_read_nxt;
  logic       dummy_pend_nxt;
  logic       rd_refuse;
  logic       rd_grant_nxt;
  logic       rd_deny_nxt;
  logic       rd_undef_nxt;

  always_comb begin
    ctl_nxt = data_store_control_r;
    if (!data_busy_r) begin
      if (ctl_wr) begin
        ctl_nxt = ctl_wdata;
      end else if (ctl_bit_wr && ctl_bit_sel == 3'(`FSGD_CTL_EN_BIT)) begin
        ctl_nxt[`FSGD_CTL_EN_BIT] = ctl_wdata[`FSGD_CTL_EN_BIT];
      end
    end
    ctl_nxt[7:1] = 7'h00;
    setup_load  = ctl_nxt[`FSGD_CTL_EN_BIT] &&
                  !data_store_control_r[`FSGD_CTL_EN_BIT];
    setup_clear = !ctl_nxt[`FSGD_CTL_EN_BIT];

    rd_refuse = ds_rd_fetch
              || !data_store_control_r[`FSGD_CTL_EN_BIT]
              || setup_busy_r
              || code_busy_r
              || clksw_busy_r;
    rd_grant_nxt = ds_rd_req && !rd_refuse;
    rd_deny_nxt  = ds_rd_req && rd_refuse;
    rd_undef_nxt = rd_grant_nxt && dummy_pend_r;
    clksw_load   = rd_undef_nxt;

    sub_read_nxt   = sub_read_r || (rd_grant_nxt && cpu_clock_source_sel);
    dummy_pend_nxt = dummy_pend_r;
    if (rd_undef_nxt) begin
      dummy_pend_nxt = 1'b0;
    end
    if (cls_q_r && !cpu_clock_source_sel && sub_read_r) begin
      dummy_pend_nxt = 1'b1;
      sub_read_nxt   = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      data_store_control_r <= `FSGD_CTL_RESET;
      cls_q_r       <= 1'b0;
      sub_read_r    <= 1'b0;
      dummy_pend_r  <= 1'b0;
      ds_rd_grant_r <= 1'b0;
      ds_rd_deny_r  <= 1'b0;
      ds_rd_undef_r <= 1'b0;
      cf_grant_r    <= 1'b0;
      stop_ok_r     <= 1'b0;
      stop_deny_r   <= 1'b0;
    end else begin
      data_store_control_r <= ctl_nxt;
      cls_q_r       <= cpu_clock_source_sel;
      sub_read_r    <= sub_read_nxt;
      dummy_pend_r  <= dummy_pend_nxt;
      ds_rd_grant_r <= rd_grant_nxt;
      ds_rd_deny_r  <= rd_deny_nxt;
      ds_rd_undef_r <= rd_undef_nxt;
      cf_grant_r    <= cf_req;
      stop_ok_r     <= stop_req && !data_busy_r && !setup_busy_r;
      stop_deny_r   <= stop_req && (data_busy_r || setup_busy_r);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks

  property p_window;
    @(posedge clk) disable iff (!nrst)
      rw_req_valid && is_self && is_code && out_win |=> rw_fail_r && !rw_go_r;
  endproperty
  a_window: assert property (p_window)
    else $error("rewrite outside window granted");

  property p_bc0;
    @(posedge clk) disable iff (!nrst)
      rw_req_valid && in_bc0 && sec_r.bc0_lock |=> !rw_go_r;
  endproperty
  a_bc0: assert property (p_bc0)
    else $error("boot cluster 0 rewrite granted while locked");

  property p_serial_erase;
    @(posedge clk) disable iff (!nrst)
      rw_req_valid && is_code && !is_self && sec_r.erase_lock
      && rw_req.op == fsgd_pkg::FSGD_OP_ERASE |=> rw_fail_r;
  endproperty
  a_serial_erase: assert property (p_serial_erase)
    else $error("serial erase passed erase lock");

  property p_sticky;
    @(posedge clk) disable iff (!nrst)
      sec_r.erase_lock || sec_r.bc0_lock |=>
        sec_r.erase_lock >= $past(sec_r.erase_lock) && sec_r.bc0_lock >= $past(sec_r.bc0_lock);
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("permanent lock cleared");

  property p_release;
    @(posedge clk) disable iff (!nrst)
      $fell(sec_r.write_lock) |-> $past(warm_rst_evt) && $past(rel_pend_r);
  endproperty
  a_release: assert property (p_release)
    else $error("write lock cleared without reset after release");

  property p_frozen;
    @(posedge clk) disable iff (!nrst)
      data_busy_r |=> data_store_control_r == $past(data_store_control_r);
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("control changed during data rewrite");

  property p_setup;
    @(posedge clk) disable iff (!nrst)
      $rose(data_store_control_r[0]) && flash_mode == fsgd_pkg::FSGD_LOW_SPEED_MAIN
      |-> (!ds_rd_grant_r) [*8];
  endproperty
  a_setup: assert property (p_setup)
    else $error("data read granted inside setup time");

  property p_code_rw;
    @(posedge clk) disable iff (!nrst)
      ds_rd_req && code_busy_r |=> ds_rd_deny_r;
  endproperty
  a_code_rw: assert property (p_code_rw)
    else $error("data read during code rewrite");

  property p_fetch;
    @(posedge clk) disable iff (!nrst)
      ds_rd_req && ds_rd_fetch |=> !ds_rd_grant_r;
  endproperty
  a_fetch: assert property (p_fetch)
    else $error("fetch from data store granted");

  property p_stop;
    @(posedge clk) disable iff (!nrst)
      stop_req && data_busy_r |=> stop_deny_r && !stop_ok_r;
  endproperty
  a_stop: assert property (p_stop)
    else $error("stop accepted during data rewrite");

endmodule : fsgd_guard
`default_nettype wire

// [fsgd_guard_test.sv]
// self-checking bench for the rewrite guard and data store gate
// assumes fsgd_pkg and fsgd_array_model are compiled before it
`timescale 1ns/1ps
`default_nettype none
module fsgd_guard_test;
  localparam logic [8:0] GO = 9'h100, FL = 9'h080, RF = 9'h040, GR = 9'h020, DN = 9'h010;
  localparam logic [8:0] UD = 9'h008, CG = 9'h004, SOK = 9'h002, SDN = 9'h001;
  localparam int RD = 0, STP = 1, CF = 2, REL = 3;
  localparam fsgd_pkg::fsgd_src_t SER = fsgd_pkg::FSGD_SRC_SERIAL, SLF = fsgd_pkg::FSGD_SRC_SELF;
  localparam fsgd_pkg::fsgd_op_t ER = fsgd_pkg::FSGD_OP_ERASE, WR = fsgd_pkg::FSGD_OP_WRITE;
  localparam fsgd_pkg::fsgd_store_t CS = fsgd_pkg::FSGD_STORE_CODE, DS = fsgd_pkg::FSGD_STORE_DATA;
  localparam int SU [3] = '{625, 90, 1250};  // enable setup in 8 ns cycles per mode
  localparam int CW [3] = '{625, 125, 1250}; // wait after the dummy read per mode

  logic clk = 1'b0;
  logic nrst, warm_rst_evt, rw_req_valid, rw_done, win_set_valid, sec_set_valid, rel_valid;
  logic code_blank, data_blank, ctl_wr, ctl_bit_wr, ds_rd_req, ds_rd_fetch, cf_req, stop_req;
  logic cpu_clock_source_sel, rw_go_r, rw_fail_r, rel_fail_r, code_busy_r, data_busy_r;
  logic ds_rd_grant_r, ds_rd_deny_r, ds_rd_undef_r, cf_grant_r, stop_ok_r, stop_deny_r;
  logic [7:0]             win_start, win_end, ctl_wdata, data_store_control_r, dly;
  logic [2:0]             ctl_bit_sel;
  logic [8:0]             seen;
  logic [8:0]             expq [$];
  fsgd_pkg::fsgd_mode_t   flash_mode;
  fsgd_pkg::fsgd_rw_req_t rw_req, rw_out_r;
  fsgd_pkg::fsgd_sec_t    sec_set_bits, sec_r;
  fsgd_pkg::fsgd_src_t    rel_src;
  int                     fails = 0;
  int                     checked = 0;
  integer                 seed = 33;

  always #4 clk = ~clk;
  assign seen = {rw_go_r, rw_fail_r, rel_fail_r, ds_rd_grant_r, ds_rd_deny_r, ds_rd_undef_r,
                 cf_grant_r, stop_ok_r, stop_deny_r};

  fsgd_guard dut_u (
    .clk(clk), .nrst(nrst), .warm_rst_evt(warm_rst_evt), .flash_mode(flash_mode),
    .rw_req_valid(rw_req_valid), .rw_req(rw_req), .rw_done(rw_done),
    .win_set_valid(win_set_valid), .win_start(win_start), .win_end(win_end),
    .sec_set_valid(sec_set_valid), .sec_set_bits(sec_set_bits), .rel_valid(rel_valid),
    .rel_src(rel_src), .code_blank(code_blank), .data_blank(data_blank), .ctl_wr(ctl_wr),
    .ctl_bit_wr(ctl_bit_wr), .ctl_bit_sel(ctl_bit_sel), .ctl_wdata(ctl_wdata),
    .ds_rd_req(ds_rd_req), .ds_rd_fetch(ds_rd_fetch), .cf_req(cf_req), .stop_req(stop_req),
    .cpu_clock_source_sel(cpu_clock_source_sel), .rw_go_r(rw_go_r), .rw_out_r(rw_out_r),
    .rw_fail_r(rw_fail_r), .rel_fail_r(rel_fail_r), .sec_r(sec_r), .code_busy_r(code_busy_r),
    .data_busy_r(data_busy_r), .data_store_control_r(data_store_control_r),
    .ds_rd_grant_r(ds_rd_grant_r), .ds_rd_deny_r(ds_rd_deny_r), .ds_rd_undef_r(ds_rd_undef_r),
    .cf_grant_r(cf_grant_r), .stop_ok_r(stop_ok_r), .stop_deny_r(stop_deny_r)
  );

  fsgd_array_model array_u (
    .clk(clk), .nrst(nrst), .rw_go(rw_go_r), .delay(dly), .rw_done(rw_done)
  );

  ////////////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] sv, input logic [15:0] ev);
    checked++;
    if (sv !== ev) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, ev, sv);
    end
  endtask : chk

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test

  // each result pulse takes the oldest expectation
  always @(negedge clk) begin
    if (nrst === 1'b1 && seen !== 9'h000) begin
      if (expq.size() == 0) chk("unexpected result", 16'(seen), 16'h0000);
      else chk("result", 16'(seen), 16'(expq.pop_front()));
    end
  end

  task automatic rst();
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    chk("locks after power-on", 16'(sec_r), 16'h0000);
    chk("control after power-on", 16'(data_store_control_r), 16'h0000);
  endtask : rst

  task automatic idle();
    repeat (int'(dly) + 4) @(posedge clk);
    for (int i = 0; i < 300 && (code_busy_r !== 1'b0 || data_busy_r !== 1'b0); i++)
      @(posedge clk);
    chk("busy cleared", {14'h0000, code_busy_r, data_busy_r}, 16'h0000);
  endtask : idle

  // f = {wide, accepted, leave running}
  task automatic rw(input fsgd_pkg::fsgd_src_t s, input fsgd_pkg::fsgd_op_t o,
                    input fsgd_pkg::fsgd_store_t st, input logic [7:0] b, input logic [2:0] f);
    expq.push_back(f[1] ? GO : FL);
    @(posedge clk);
    rw_req_valid <= 1'b1;
    rw_req <= '{src: s, op: o, store: st, block: b, wide: f[2]};
    @(posedge clk);
    rw_req_valid <= 1'b0;
    @(posedge clk);
    chk("forwarded request", 16'(rw_out_r), 16'({s, o, st, b, f[2]}));
    if (f[1] && !f[0]) idle();
    else @(posedge clk);
  endtask : rw

  task automatic req(input int k, input logic [8:0] e);
    if (e != 9'h000) expq.push_back(e);
    @(posedge clk);
    case (k)
      RD:      ds_rd_req <= 1'b1;
      STP:     stop_req <= 1'b1;
      CF:      cf_req <= 1'b1;
      default: rel_valid <= 1'b1;
    endcase
    @(posedge clk);
    {ds_rd_req, stop_req, cf_req, rel_valid} <= 4'h0;
    @(posedge clk);
  endtask : req

  task automatic ctl(input logic bm, input logic [7:0] d);
    @(posedge clk);
    ctl_wr <= ~bm;
    ctl_bit_wr <= bm;
    ctl_wdata <= d;
    @(posedge clk);
    {ctl_wr, ctl_bit_wr} <= 2'b00;
    @(posedge clk);
    @(negedge clk);
  endtask : ctl

  // k: 0 window, 1 lock set, other device reset keeping locks
  task automatic cfg(input int k, input logic [7:0] a, input logic [7:0] b);
    @(posedge clk);
    case (k)
      0: {win_set_valid, win_start, win_end} <= {1'b1, a, b};
      1: {sec_set_valid, sec_set_bits} <= {1'b1, a[2:0]};
      default: warm_rst_evt <= 1'b1;
    endcase
    @(posedge clk);
    {win_set_valid, sec_set_valid, warm_rst_evt} <= 3'b000;
    @(posedge clk);
    @(negedge clk);
  endtask : cfg

  ////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    end_of_test();
  end

  initial begin
    logic [7:0] b;
    logic       o;
    {warm_rst_evt, rw_req_valid, win_set_valid, sec_set_valid, rel_valid, ctl_wr, ctl_bit_wr,
     ds_rd_req, ds_rd_fetch, cf_req, stop_req, cpu_clock_source_sel} = '0;
    {win_start, win_end, ctl_wdata, ctl_bit_sel, sec_set_bits, rw_req} = '0;
    flash_mode = fsgd_pkg::FSGD_HIGH_SPEED_MAIN;
    rel_src = SER;
    {code_blank, data_blank} = 2'b11;
    dly = 8'h08;
    nrst = 1'b0;
    rst();
    for (int m = 0; m < 3; m++) begin
      flash_mode <= fsgd_pkg::fsgd_mode_t'(m);
      ctl(1'b0, 8'hff);
      chk("control byte write", 16'(data_store_control_r), 16'h0001);
      req(RD, DN);
      req(STP, SDN);
      ctl(1'b1, 8'h00);
      req(STP, SOK);
      ctl(1'b1, 8'h01);
      repeat (SU[m] - 12) @(posedge clk);
      req(RD, DN);
      repeat (16) @(posedge clk);
      repeat (3) @(posedge clk); // idle three clocks before the read
      @(posedge clk); // no-op slot just ahead of the read
      req(RD, GR);
      cpu_clock_source_sel <= 1'b1;
      req(RD, GR);
      cpu_clock_source_sel <= 1'b0;
      req(RD, GR | UD);
      req(RD, DN);
      repeat (CW[m]) @(posedge clk);
      req(RD, GR);
      ctl(1'b0, 8'h00);
    end
    $display("setup and clock switch test done");
    cfg(0, 8'h04, 8'h06);
    rw(SLF, WR, CS, 8'h03, 3'b000);
    rw(SLF, ER, CS, 8'h04, 3'b010);
    rw(SLF, WR, CS, 8'h06, 3'b010);
    rw(SLF, ER, CS, 8'h07, 3'b000);
    rw(SER, WR, CS, 8'h07, 3'b010);
    rw(SLF, WR, DS, 8'h40, 3'b010);
    rw(SLF, WR, DS, 8'h41, 3'b100);
    for (int i = 0; i < 8; i++) begin
      b = 8'h07 + 8'($unsigned($random(seed)) % 249);
      o = 1'($random(seed));
      rw(SLF, fsgd_pkg::fsgd_op_t'(o), CS, b, 3'b000);
    end
    $display("window test done");
    flash_mode <= fsgd_pkg::FSGD_LOW_SPEED_MAIN;
    dly <= 8'h3c;
    ctl(1'b0, 8'h01);
    repeat (100) @(posedge clk);
    ds_rd_fetch <= 1'b1;
    req(RD, DN);
    ds_rd_fetch <= 1'b0;
    rw(SLF, WR, CS, 8'h05, 3'b011);
    req(RD, DN);
    rw(SLF, WR, CS, 8'h05, 3'b000);
    idle();
    rw(SLF, WR, DS, 8'h02, 3'b011);
    ctl(1'b0, 8'h00);
    chk("control frozen while busy", 16'(data_store_control_r), 16'h0001);
    req(STP, SDN);
    req(CF, CG);
    idle();
    ctl(1'b0, 8'h00);
    chk("control cleared", 16'(data_store_control_r), 16'h0000);
    ctl_bit_sel <= 3'h1;
    ctl(1'b1, 8'hff);
    chk("other bit write ignored", 16'(data_store_control_r), 16'h0000);
    ctl_bit_sel <= 3'h0;
    $display("busy interlock test done");
    dly <= 8'h08;
    cfg(0, 8'h00, 8'hff);
    cfg(1, 8'h01, 8'h00);
    chk("boot lock set", 16'(sec_r), 16'h0001);
    rw(SLF, WR, CS, 8'h03, 3'b000);
    rw(SER, ER, CS, 8'h00, 3'b000);
    rw(SER, WR, CS, 8'h04, 3'b010);
    cfg(1, 8'h04, 8'h00);
    rw(SER, ER, CS, 8'h08, 3'b000);
    rw(SLF, ER, CS, 8'h08, 3'b010);
    cfg(1, 8'h02, 8'h00);
    rw(SER, WR, CS, 8'h09, 3'b000);
    rw(SLF, WR, CS, 8'h09, 3'b010);
    req(REL, RF);
    cfg(2, 8'h00, 8'h00);
    chk("locks kept over reset", 16'(sec_r), 16'h0007);
    $display("lock test done");
    rst();
    cfg(1, 8'h02, 8'h00);
    rel_src <= SLF;
    req(REL, RF);
    rel_src <= SER;
    code_blank <= 1'b0;
    req(REL, RF);
    code_blank <= 1'b1;
    req(REL, 9'h000);
    @(negedge clk);
    chk("release pending", 16'(sec_r), 16'h0002);
    cfg(2, 8'h00, 8'h00);
    chk("release applied", 16'(sec_r), 16'h0000);
    $display("release test done");
    chk("results left", 16'(expq.size()), 16'h0000);
    end_of_test();
  end
endmodule : fsgd_guard_test
`default_nettype wire

// [fsgd_pkg.sv]
// types shared by the guard and its test bench
// assumes fsgd_defines.svh supplies the numbers
package fsgd_pkg;

  typedef enum logic [1:0] {
    FSGD_HIGH_SPEED_MAIN,
    FSGD_LOW_SPEED_MAIN,
    FSGD_LOW_VOLTAGE_MAIN
  } fsgd_mode_t;

  typedef enum logic {
    FSGD_SRC_SERIAL,
    FSGD_SRC_SELF
  } fsgd_src_t;

  typedef enum logic {
    FSGD_OP_ERASE,
    FSGD_OP_WRITE
  } fsgd_op_t;

  typedef enum logic {
    FSGD_STORE_CODE,
    FSGD_STORE_DATA
  } fsgd_store_t;

  typedef struct packed {
    fsgd_src_t   src;
    fsgd_op_t    op;
    fsgd_store_t store;
    logic [7:0]  block;
    logic        wide;
  } fsgd_rw_req_t;

  typedef struct packed {
    logic erase_lock;
    logic write_lock;
    logic bc0_lock;
  } fsgd_sec_t;

endpackage : fsgd_pkg

// [fsgd_timer.sv]
// one-shot down counter; busy while counting
// assumes load and clear come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module fsgd_timer (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        load,
  input  wire logic [10:0] count,
  input  wire logic        clear,
  output var  logic        busy_r
);

  logic [10:0] cnt_r;
  logic [10:0] cnt_nxt;
  logic        busy_nxt;

  always_comb begin
    cnt_nxt  = cnt_r;
    busy_nxt = busy_r;
    if (clear) begin
      cnt_nxt  = 11'h000;
      busy_nxt = 1'b0;
    end else if (load) begin
      cnt_nxt  = count;
      busy_nxt = (count != 11'h000);
    end else if (busy_r) begin
      cnt_nxt  = cnt_r - 11'h001;
      busy_nxt = (cnt_r != 11'h001);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r  <= 11'h000;
      busy_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      busy_r <= busy_nxt;
    end
  end

endmodule : fsgd_timer
`default_nettype wire
